// File: core/ssfi_core.sv
// full step coil driver with back emf integrator and apb register slave
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ssfi_core
   import ssfi_pkg::*;
(
   input  wire logic        mclk_i,           // 10 MHz bus clock
   input  wire logic        rstn_i,           // async reset, active low
   input  wire logic        psel_i,           // apb select
   input  wire logic        penable_i,        // apb access phase
   input  wire logic        pwrite_i,         // apb direction
   input  wire logic [7:0]  paddr_i,          // apb byte address
   input  wire logic [31:0] pwdata_i,         // apb write data
   output logic      [31:0] prdata_o,         // apb read data
   output logic             pready_o,         // apb ready
   output logic             pslverr_o,        // apb error, unmapped address
   input  wire logic        coil_a_plus_i,    // pin levels seen by integrator
   input  wire logic        coil_a_minus_i,
   input  wire logic        coil_b_plus_i,
   input  wire logic        coil_b_minus_i,
   output logic             coil_a_plus_o,    // pin drive levels
   output logic             coil_a_minus_o,
   output logic             coil_b_plus_o,
   output logic             coil_b_minus_o,
   output logic             coil_a_plus_oe_o, // pin drive enables
   output logic             coil_a_minus_oe_o,
   output logic             coil_b_plus_oe_o,
   output logic             coil_b_minus_oe_o
);

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  ctrl;     // control register
      logic [8:0]  pre;      // prescaler count
      ssfi_seg_t   seg;      // present segment
      logic [15:0] count;    // modulus down counter
      logic [15:0] half;     // half of loaded value
      logic        armed;    // load seen with counter on, integration off
      logic        offs;     // offset phase swapped
      logic [15:0] accum;    // signed accumulator
      logic        ovf;      // sticky overflow
      logic [31:0] rdata;    // apb read data
      logic        ready;    // apb ready
      logic        err;      // apb error
      logic [3:0]  pin;      // drive levels a+,a-,b+,b-
      logic [3:0]  oe;       // drive enables a+,a-,b+,b-
   } ssfi_state_t;

   ssfi_state_t s;       // registered state
   ssfi_state_t next_s;  // next state

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   // pin levels for a segment: driven coil opposite, idle coil both low
   function automatic logic [3:0] seg_pins(input ssfi_seg_t seg);
      logic [3:0] p;
      p = 4'h0;
      unique case (seg)
         SEG_A_POS: p = 4'h8;
         SEG_B_POS: p = 4'h2;
         SEG_A_NEG: p = 4'h4;
         SEG_B_NEG: p = 4'h1;
      endcase
      return p;
   endfunction

   // coil b idle in the a segments, coil a idle in the b segments
   function automatic logic b_idle(input ssfi_seg_t seg);
      return (seg == SEG_A_POS) || (seg == SEG_A_NEG);
   endfunction

   logic        acc_write;   // apb write access this cycle
   logic        acc_read;    // apb read access this cycle
   logic        mapped;      // address hits a register
   logic        tick;        // prescaled modulus clock
   logic        integ;       // integration running
   logic        sp, sm;      // integrator inputs after routing
   logic [1:0]  inc;         // signed -1, 0, +1
   logic [16:0] sum;         // widened sum for overflow test
   logic [15:0] dec;         // count minus one

   // ------------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------------
   always_comb begin
      next_s    = s;
      mapped    = (paddr_i == SSFI_CTRL_OFS) || (paddr_i == SSFI_STEP_OFS) ||
                  (paddr_i == SSFI_MODCNT_OFS) || (paddr_i == SSFI_ACCUM_OFS) ||
                  (paddr_i == SSFI_STATUS_OFS);
      acc_write = psel_i && penable_i && s.ready && pwrite_i && mapped;
      acc_read  = psel_i && penable_i && !s.ready && !pwrite_i;
      // prescaler wraps at 64 or 512 bus clocks
      tick      = s.pre == (s.ctrl[SSFI_CTRL_PRE] ? SSFI_DIV512_LAST : SSFI_DIV64_LAST);
      next_s.pre = tick ? 9'h000 : s.pre + 9'h001;
      integ     = s.ctrl[SSFI_CTRL_INT_EN] && s.ctrl[SSFI_CTRL_CNT_EN] && (s.count != 16'h0000);
      dec       = s.count - 16'h0001;

      // modulus counter runs down to zero and stops there
      if (tick && s.ctrl[SSFI_CTRL_CNT_EN] && (s.count != 16'h0000)) begin
         next_s.count = dec;
         // offset swap only when the recommended order armed it
         if (s.armed && integ && (dec == s.half)) begin
            next_s.offs = !s.offs;
         end
      end

      // idle coil pins feed the integrator, polarity swaps the pair
      if (b_idle(s.seg)) begin
         sp = s.ctrl[SSFI_CTRL_POL] ? coil_b_minus_i : coil_b_plus_i;
         sm = s.ctrl[SSFI_CTRL_POL] ? coil_b_plus_i  : coil_b_minus_i;
      end else begin
         sp = s.ctrl[SSFI_CTRL_POL] ? coil_a_minus_i : coil_a_plus_i;
         sm = s.ctrl[SSFI_CTRL_POL] ? coil_a_plus_i  : coil_a_minus_i;
      end
      inc = (sp && !sm) ? 2'h1 : ((!sp && sm) ? 2'h3 : 2'h0);
      sum = {s.accum[15], s.accum} + {{15{inc[1]}}, inc};
      if (tick && integ) begin
         next_s.accum = sum[15:0];
         if (sum[16] != sum[15]) begin
            next_s.ovf = 1'b1;
         end
      end

      // apb: one wait state, effects at the completing edge
      next_s.ready = psel_i && penable_i && !s.ready;
      next_s.err   = psel_i && penable_i && !s.ready && !mapped;
      if (acc_read) begin
         unique case (paddr_i)
            SSFI_CTRL_OFS:   next_s.rdata = {27'h0000000, s.ctrl};
            SSFI_MODCNT_OFS: next_s.rdata = {16'h0000, s.count};
            SSFI_ACCUM_OFS:  next_s.rdata = {16'h0000, s.accum};
            SSFI_STATUS_OFS: next_s.rdata = {27'h0000000, s.seg, s.offs,
                                             s.count == 16'h0000, s.ovf};
            default:         next_s.rdata = 32'h00000000;
         endcase
      end
      if (acc_write) begin
         unique case (paddr_i)
            SSFI_CTRL_OFS: begin
               next_s.ctrl = pwdata_i[SSFI_CTRL_W-1:0];
               if (pwdata_i[SSFI_CTRL_INT_EN] && !s.ctrl[SSFI_CTRL_INT_EN]) begin
                  next_s.offs = 1'b0;
               end
            end
            SSFI_STEP_OFS: begin
               // fixed order, forward or back one quarter period
               next_s.seg = s.ctrl[SSFI_CTRL_DIR] ? ssfi_seg_t'(s.seg - 2'h1)
                                                  : ssfi_seg_t'(s.seg + 2'h1);
            end
            SSFI_MODCNT_OFS: begin
               next_s.count = pwdata_i[15:0];
               next_s.half  = {1'b0, pwdata_i[15:1]};
               next_s.armed = s.ctrl[SSFI_CTRL_CNT_EN] && !s.ctrl[SSFI_CTRL_INT_EN];
               next_s.offs  = 1'b0;
            end
            SSFI_ACCUM_OFS: begin
               next_s.accum = 16'h0000;  // any write restarts the sum
            end
            SSFI_STATUS_OFS: begin
               // a new overflow in the same cycle beats the clear
               if (pwdata_i[SSFI_STAT_OVF] && !(tick && integ && (sum[16] != sum[15]))) begin
                  next_s.ovf = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // pins follow the next segment; idle coil floats while integrate_enable is set
      next_s.pin = seg_pins(next_s.seg);
      next_s.oe  = 4'hF;
      if (next_s.ctrl[SSFI_CTRL_INT_EN]) begin
         next_s.oe = b_idle(next_s.seg) ? 4'hC : 4'h3;
      end
   end

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s       <= '0;
         s.ctrl  <= SSFI_CTRL_RST;
         s.count <= SSFI_COUNT_RST;
         s.pin   <= 4'h8;
         s.oe    <= 4'hF;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign prdata_o          = s.rdata;
   assign pready_o          = s.ready;
   assign pslverr_o         = s.err;
   assign coil_a_plus_o     = s.pin[3];
   assign coil_a_minus_o    = s.pin[2];
   assign coil_b_plus_o     = s.pin[1];
   assign coil_b_minus_o    = s.pin[0];
   assign coil_a_plus_oe_o  = s.oe[3];
   assign coil_a_minus_oe_o = s.oe[2];
   assign coil_b_plus_oe_o  = s.oe[1];
   assign coil_b_minus_oe_o = s.oe[0];

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   idle_coil_equal_a: assert property (s.oe[1:0] == 2'h3 && b_idle(s.seg) |-> s.pin[1] == s.pin[0])
      else $error("idle coil b pins differ");
   driven_coil_opp_a: assert property (s.pin[3] != s.pin[2] || s.pin[1] != s.pin[0])
      else $error("no coil driven");
   quarter_apart_a: assert property (s.pin[3:2] != 2'h0 |-> s.pin[1:0] == 2'h0)
      else $error("both coils driven");
   step_advance_a: assert property (acc_write && paddr_i == SSFI_STEP_OFS && !s.ctrl[SSFI_CTRL_DIR]
                                    |=> s.seg == ssfi_seg_t'($past(s.seg) + 2'h1))
      else $error("forward step wrong segment");
   float_idle_a: assert property (s.ctrl[SSFI_CTRL_INT_EN] && b_idle(s.seg) |-> s.oe == 4'hC)
      else $error("idle coil still driven");
   count_down_a: assert property (tick && integ && !acc_write |=> s.count == $past(s.count) - 16'h0001)
      else $error("counter not decremented");
   tick_gap_a: assert property (tick && !s.ctrl[SSFI_CTRL_PRE] && !$past(acc_write)
                                |=> !tick [*8])
      else $error("prescaler ticked early");
   ovf_set_a: assert property (tick && integ && sum[16] != sum[15] |=> s.ovf)
      else $error("overflow not flagged");
   ovf_sticky_a: assert property (s.ovf && !(acc_write && paddr_i == SSFI_STATUS_OFS) |=> s.ovf)
      else $error("overflow lost");
   pol_swap_a: assert property (!b_idle(s.seg) && s.ctrl[SSFI_CTRL_POL] |-> sp == coil_a_minus_i)
      else $error("polarity not swapped");
   offs_half_a: assert property ($changed(s.offs) && !$past(acc_write) |-> s.count == s.half && s.armed)
      else $error("offset swap off half point");
   acc_snap_a: assert property (acc_read && paddr_i == SSFI_ACCUM_OFS |=> prdata_o[15:0] == $past(s.accum))
      else $error("accumulator read wrong");

   step_cov_c:  cover property (acc_write && paddr_i == SSFI_STEP_OFS ##1 s.seg == SEG_B_POS);
   offs_cov_c:  cover property (s.armed && integ ##1 $changed(s.offs));
   ovf_cov_c:   cover property ($rose(s.ovf));
   done_cov_c:  cover property (integ ##1 s.count == 16'h0000);

endmodule
`default_nettype wire

// File: core/ssfi_pkg.sv
// constants and types for the stepper full step integrator
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ssfi_pkg;

   // register byte offsets
   localparam logic [7:0] SSFI_CTRL_OFS   = 8'h00;  // control bits
   localparam logic [7:0] SSFI_STEP_OFS   = 8'h04;  // any write = one full step
   localparam logic [7:0] SSFI_MODCNT_OFS = 8'h08;  // write load value, read count
   localparam logic [7:0] SSFI_ACCUM_OFS  = 8'h0C;  // signed accumulator snapshot
   localparam logic [7:0] SSFI_STATUS_OFS = 8'h10;  // status, write 1 clears flag

   // control field positions
   localparam int SSFI_CTRL_CNT_EN = 0;  // modcount_enable
   localparam int SSFI_CTRL_INT_EN = 1;  // integrate_enable
   localparam int SSFI_CTRL_POL    = 2;  // integrator polarity
   localparam int SSFI_CTRL_PRE    = 3;  // 0 divide 64, 1 divide 512
   localparam int SSFI_CTRL_DIR    = 4;  // 0 forward, 1 reverse
   localparam int SSFI_CTRL_W      = 5;

   // status field positions
   localparam int SSFI_STAT_OVF  = 0;  // accumulator overflow, sticky
   localparam int SSFI_STAT_DONE = 1;  // modulus count at zero
   localparam int SSFI_STAT_OFFS = 2;  // offset cancel phase swapped
   localparam int SSFI_STAT_SEG  = 3;  // segment, two bits

   // reset values
   localparam logic [4:0]  SSFI_CTRL_RST  = 5'h00;
   localparam logic [15:0] SSFI_COUNT_RST = 16'h0000;

   // prescaler terminal counts
   localparam logic [8:0] SSFI_DIV64_LAST  = 9'h03F;
   localparam logic [8:0] SSFI_DIV512_LAST = 9'h1FF;

   // quarter period segments in fixed forward order
   typedef enum logic [1:0] {SEG_A_POS, SEG_B_POS, SEG_A_NEG, SEG_B_NEG} ssfi_seg_t;

endpackage

// File: dv/ssfi_motor_model.sv
// motor coil model: wire levels of the four coil pins
`timescale 1ns/100ps
`default_nettype none
module ssfi_motor_model (
   input  wire logic [3:0] drv_i,   // drive levels a+,a-,b+,b-
   input  wire logic [3:0] oe_i,    // drive enables a+,a-,b+,b-
   input  wire logic [1:0] emf_i,   // back emf on a released coil, plus/minus
   output logic      [3:0] sense_o  // wire level seen at each pin
);
   // ------------------------------------------------------------
   // pin levels
   // ------------------------------------------------------------
   // a driven pin shows its rail level; a released coil shows its
   // induced voltage, never the last driven value
   assign sense_o[3] = oe_i[3] ? drv_i[3] : emf_i[1];
   assign sense_o[2] = oe_i[2] ? drv_i[2] : emf_i[0];
   assign sense_o[1] = oe_i[1] ? drv_i[1] : emf_i[1];
   assign sense_o[0] = oe_i[0] ? drv_i[0] : emf_i[0];
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking testbench for the stepper full step integrator
`timescale 1ns/100ps
`default_nettype none
module tb
   import ssfi_pkg::*;
;
   logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  drv, oe, sense;   // pins a+,a-,b+,b-
   logic [1:0]  emf;              // induced level on a released coil
   int          fails, comparisons;

   ssfi_core DUT (.mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .coil_a_plus_i(sense[3]), .coil_a_minus_i(sense[2]), .coil_b_plus_i(sense[1]),
      .coil_b_minus_i(sense[0]), .coil_a_plus_o(drv[3]), .coil_a_minus_o(drv[2]),
      .coil_b_plus_o(drv[1]), .coil_b_minus_o(drv[0]), .coil_a_plus_oe_o(oe[3]),
      .coil_a_minus_oe_o(oe[2]), .coil_b_plus_oe_o(oe[1]), .coil_b_minus_oe_o(oe[0]));
   ssfi_motor_model motor (.drv_i(drv), .oe_i(oe), .emf_i(emf), .sense_o(sense));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic complete_run;
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one bit wider than a data word so that pslverr can ride along with read data
   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         $display("FAIL %0t %s", $time, msg);
         fails++;
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         $display("FAIL %0t bus timeout", $time);
         fails++;
         complete_run();
      end
      @(posedge mclk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_regs;
      chk({drv, oe}, 8'h8F, "reset pins");
      xfer(SSFI_CTRL_OFS, 1'b0, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      xfer(SSFI_STATUS_OFS, 1'b0, 32'h0);
      chk(rd, 32'h2, "status reset");
      xfer(SSFI_STATUS_OFS, 1'b1, 32'h1);
      xfer(SSFI_STATUS_OFS, 1'b0, 32'h0);
      chk(rd, 32'h2, "status after clear");
      xfer(8'h14, 1'b0, 32'h0);
      chk({er, rd}, 33'h100000000, "unmapped read");
      xfer(8'h14, 1'b1, 32'hFFFFFFFF);
      chk(er, 1'b1, "unmapped write");
      xfer(SSFI_STEP_OFS, 1'b0, 32'h0);
      chk({er, rd}, 33'h0, "step read");
   endtask

   // four forward steps, then two in reverse, from segment a positive
   task automatic t_steps;
      logic [3:0] pins [4];
      int         seg [6];
      pins = '{4'h8, 4'h2, 4'h4, 4'h1};
      seg = '{1, 2, 3, 0, 3, 2};
      for (int i = 0; i < 6; i++) begin
         if (i == 4)
            xfer(SSFI_CTRL_OFS, 1'b1, 32'h10);
         xfer(SSFI_STEP_OFS, 1'b1, 32'h0);
         chk({drv, oe}, {pins[seg[i]], 4'hF}, "step pins");
         xfer(SSFI_STATUS_OFS, 1'b0, 32'h0);
         chk(rd[4:3], seg[i][1:0], "step segment");
      end
   endtask

   // integration window in segment a negative; coil b is sensed
   task automatic t_integ(input logic pre, input logic pol, input logic armed, input int n,
                          input logic [15:0] exp);
      logic [31:0] c;
      time         t0;
      int          k;
      int          dv;
      c = {27'h0, 1'b0, pre, pol, 2'b00};
      dv = pre ? 512 : 64;
      xfer(SSFI_ACCUM_OFS, 1'b1, 32'h0);
      if (armed) begin
         xfer(SSFI_CTRL_OFS, 1'b1, c | 32'h1);
         xfer(SSFI_MODCNT_OFS, 1'b1, n);
         xfer(SSFI_CTRL_OFS, 1'b1, c | 32'h3);
      end else begin
         xfer(SSFI_CTRL_OFS, 1'b1, c | 32'h3);
         xfer(SSFI_MODCNT_OFS, 1'b1, n);
      end
      t0 = $time;
      chk(oe, 4'hC, "idle coil released");
      k = 0;
      do begin
         xfer(SSFI_MODCNT_OFS, 1'b0, 32'h0);
         k++;
      end while (rd[15:0] !== 16'h0 && k < 2000);
      // a window that never closes ends the run here
      if (rd[15:0] !== 16'h0) begin
         $display("FAIL %0t count timeout", $time);
         fails++;
         complete_run();
      end
      chk(rd, 32'h0, "count at zero");
      chk(($time - t0) >= (n - 1) * dv * 100 && ($time - t0) <= (n * dv + 12) * 100, 1, "window time");
      xfer(SSFI_ACCUM_OFS, 1'b0, 32'h0);
      chk(rd, {16'h0, exp}, "accumulated value");
      xfer(SSFI_STATUS_OFS, 1'b0, 32'h0);
      chk(rd[2:0], {armed, 2'b10}, "window status");
      xfer(SSFI_CTRL_OFS, 1'b1, 32'h0);
   endtask

   // ------------------------------------------------------------
   // clock, reset and main sequence
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; emf = 2'b10;
      fails = 0; comparisons = 0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      t_reset_regs();
      t_steps();
      t_integ(1'b0, 1'b0, 1'b1, 6, 16'h0006);
      t_integ(1'b1, 1'b0, 1'b1, 3, 16'h0003);
      t_integ(1'b0, 1'b1, 1'b1, 5, 16'hFFFB);
      t_integ(1'b0, 1'b0, 1'b0, 4, 16'h0004);
      complete_run();
   end
endmodule
`default_nettype wire
